// file: basic_timer_watchdog_regs.svh
`ifndef BASIC_TIMER_WATCHDOG_REGS_SVH
`define BASIC_TIMER_WATCHDOG_REGS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define TBW_IDX_CONTROL      16'hA002
`define TBW_IDX_COUNT        16'hA007
`define TBW_IDX_SYS_CONFIG   16'hA010
`define TBW_IDX_IRQ_STATUS   16'hA011
`define TBW_IDX_IRQ_MASK     16'hA012
`define TBW_ADDR_WIDTH       18
`define TBW_ADDR_CONTROL     18'h28008
`define TBW_ADDR_COUNT       18'h2801C
`define TBW_ADDR_SYS_CONFIG  18'h28040
`define TBW_ADDR_IRQ_STATUS  18'h28044
`define TBW_ADDR_IRQ_MASK    18'h28048

// ==========================================================================
// Field positions
`define TBW_CTRL_GUARD_CLR   0
`define TBW_CTRL_TB_CLR      1
`define TBW_CTRL_SEL_LSB     2
`define TBW_CTRL_SEL_MSB     3
`define TBW_CTRL_CODE_LSB    8
`define TBW_CTRL_CODE_MSB    15
`define TBW_CFG_STOP_BIT     6
`define TBW_IRQ_INTERVAL_BIT 0
`define TBW_IRQ_START_BIT    1
`define TBW_START_BIT        4

// ==========================================================================
// Reset values and codes
`define TBW_GUARD_STOP_CODE  8'hA5
`define TBW_RST_CODE         8'h00
`define TBW_RST_SEL          2'h0
`define TBW_RST_STOP         1'h0
`define TBW_RST_MASK         2'h0

// ==========================================================================
// Prescaler divide exponents
`define TBW_PRESCALE_WIDTH   13
`define TBW_DIV_SEL3         9
`define TBW_DIV_SEL2         11
`define TBW_DIV_SEL1         12
`define TBW_DIV_SEL0         13
`define TBW_TB_INTERVAL      256
`endif

// file: basic_timer_watchdog_pkg.sv
package basic_timer_watchdog_pkg;
  typedef logic [7:0]  timebase_type;
  typedef logic [2:0]  guard_type;
  typedef logic [1:0]  clk_sel_type;
  typedef logic [1:0]  irq_bits_type;
  typedef enum logic [2:0] {
    START_WAIT_LOW  = 3'b001,
    START_WAIT_RISE = 3'b010,
    START_RUN       = 3'b100
  } start_state_type;
endpackage : basic_timer_watchdog_pkg

// file: timebase_prescaler.sv
`include "basic_timer_watchdog_regs.svh"
module timebase_prescaler
  import basic_timer_watchdog_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire clk_sel_type i_clk_sel,
  input  wire logic        i_rst,
  output logic             o_tick
);
  logic [`TBW_PRESCALE_WIDTH-1:0] div_count;
  logic [`TBW_PRESCALE_WIDTH-1:0] tap_mask;

  // ==========================================================================
  // Free-running divider
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + 1'b1;
    end
  end

  // ==========================================================================
  // Tap selection
  always_comb begin
    case (i_clk_sel)
      2'h3:    tap_mask = `TBW_PRESCALE_WIDTH'((1 << `TBW_DIV_SEL3) - 1);
      2'h2:    tap_mask = `TBW_PRESCALE_WIDTH'((1 << `TBW_DIV_SEL2) - 1);
      2'h1:    tap_mask = `TBW_PRESCALE_WIDTH'((1 << `TBW_DIV_SEL1) - 1);
      default: tap_mask = `TBW_PRESCALE_WIDTH'((1 << `TBW_DIV_SEL0) - 1);
    endcase
  end

  // Selection change mid-period just shortens or stretches one period, no glitch
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= ((div_count & tap_mask) == tap_mask);
    end
  end

  property p_tick_sel3;
    @(posedge i_sys_clk) disable iff (i_rst)
      (i_clk_sel == 2'h3 && $stable(i_clk_sel) && o_tick) |-> (div_count[8:0] == 9'h000);
  endproperty
  a_tick_sel3: assert property (p_tick_sel3) else $error("tick not on 2^9 boundary");
endmodule : timebase_prescaler

// file: basic_timer_watchdog.sv
`include "basic_timer_watchdog_regs.svh"
module basic_timer_watchdog
  import basic_timer_watchdog_pkg::*;
(
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_halt_release,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [`TBW_ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic [31:0]                     o_prdata,
  output logic                            o_pready,
  output logic                            o_pslverr,
  output logic                            o_irq,
  output logic                            o_guard_reset,
  output logic                            o_cpu_start
);
  // ==========================================================================
  // State
  timebase_type    timebase_counter;
  guard_type       guard_counter;
  clk_sel_type     clk_sel;
  logic [7:0]      guard_code;
  logic            tb_stop;
  irq_bits_type    irq_status;
  irq_bits_type    irq_mask;
  irq_bits_type    irq_event;
  logic            clr_guard;
  logic            clr_tb;
  logic            tick;
  logic            tb_overflow;
  logic            guard_enabled;
  logic            guard_overflow;
  logic            bit4_prev;
  logic            start_event;
  start_state_type start_state;

  logic            setup;
  logic            wr_access;
  logic            rd_setup;
  logic            addr_hit;
  logic            status_read;
  logic [31:0]     next_rdata;

  timebase_prescaler u_prescaler (
    .i_sys_clk (i_sys_clk),
    .i_clk_sel (clk_sel),
    .i_rst     (i_rst),
    .o_tick    (tick)
  );

  // ==========================================================================
  // Bus decode: zero-wait answer in the first access cycle
  assign setup    = psel && !penable;
  assign rd_setup = setup && !pwrite;

  always_comb begin
    addr_hit   = 1'b1;
    next_rdata = 32'h0000_0000;
    case (paddr)
      `TBW_ADDR_CONTROL:    next_rdata = {16'h0000, guard_code, 4'h0, clk_sel, 2'h0};
      `TBW_ADDR_COUNT:      next_rdata = {24'h000000, timebase_counter};
      `TBW_ADDR_SYS_CONFIG: next_rdata = {25'h0000000, tb_stop, 6'h00};
      `TBW_ADDR_IRQ_STATUS: next_rdata = {30'h00000000, irq_status};
      `TBW_ADDR_IRQ_MASK:   next_rdata = {30'h00000000, irq_mask};
      default:              addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup && !addr_hit;
      o_prdata  <= rd_setup ? next_rdata : 32'h0000_0000;
    end
  end

  // Status read-clear takes effect at the completing edge
  assign status_read = psel && penable && o_pready && !pwrite && (paddr == `TBW_ADDR_IRQ_STATUS);

  // Writes land at the completing edge too, never in the setup cycle
  assign wr_access   = psel && penable && o_pready && pwrite;

  // ==========================================================================
  // Control register; count register has no write path
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      guard_code <= `TBW_RST_CODE;
      clk_sel    <= `TBW_RST_SEL;
    end else if (wr_access && paddr == `TBW_ADDR_CONTROL) begin
      if (pstrb[0]) begin
        clk_sel <= pwdata[`TBW_CTRL_SEL_MSB:`TBW_CTRL_SEL_LSB];
      end
      if (pstrb[1]) begin
        guard_code <= pwdata[`TBW_CTRL_CODE_MSB:`TBW_CTRL_CODE_LSB];
      end
    end
  end

  // Clear bits never store; they read back zero
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      clr_guard <= 1'b0;
      clr_tb    <= 1'b0;
    end else begin
      clr_guard <= wr_access && paddr == `TBW_ADDR_CONTROL && pstrb[0] && pwdata[`TBW_CTRL_GUARD_CLR];
      clr_tb    <= wr_access && paddr == `TBW_ADDR_CONTROL && pstrb[0] && pwdata[`TBW_CTRL_TB_CLR];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tb_stop  <= `TBW_RST_STOP;
      irq_mask <= `TBW_RST_MASK;
    end else if (wr_access && pstrb[0]) begin
      if (paddr == `TBW_ADDR_SYS_CONFIG) begin
        tb_stop <= pwdata[`TBW_CFG_STOP_BIT];
      end
      if (paddr == `TBW_ADDR_IRQ_MASK) begin
        irq_mask <= pwdata[1:0];
      end
    end
  end

  // ==========================================================================
  // Timebase counter
  assign tb_overflow = tick && !tb_stop && !clr_tb && (timebase_counter == 8'hFF);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      timebase_counter <= 8'h00;
    end else if (clr_tb) begin
      timebase_counter <= 8'h00;
    end else if (tick && !tb_stop) begin
      timebase_counter <= timebase_counter + 8'h01;
    end
  end

  // ==========================================================================
  // Guard counter, clocked only by timebase overflow
  assign guard_enabled  = (guard_code != `TBW_GUARD_STOP_CODE);
  assign guard_overflow = guard_enabled && tb_overflow && !clr_guard && (guard_counter == 3'h7);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      guard_counter <= 3'h0;
    end else if (clr_guard) begin
      guard_counter <= 3'h0;
    end else if (tb_overflow && guard_enabled) begin
      guard_counter <= guard_counter + 3'h1;
    end
  end

  // Pulse feeds system reset, which then clears this block too
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_guard_reset <= 1'b0;
    end else begin
      o_guard_reset <= guard_overflow;
    end
  end

  // ==========================================================================
  // Processor start gate
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      bit4_prev <= 1'b0;
    end else begin
      bit4_prev <= timebase_counter[`TBW_START_BIT];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      start_state <= START_WAIT_RISE;
    end else if (i_halt_release) begin
      start_state <= START_WAIT_RISE;
    end else begin
      case (start_state)
        START_WAIT_LOW:  start_state <= START_WAIT_RISE;
        START_WAIT_RISE: begin
          if (timebase_counter[`TBW_START_BIT] && !bit4_prev) begin
            start_state <= START_RUN;
          end
        end
        START_RUN:       start_state <= START_RUN;
        default:         start_state <= START_WAIT_RISE;
      endcase
    end
  end

  assign start_event = (start_state == START_WAIT_RISE) && !i_halt_release
                       && timebase_counter[`TBW_START_BIT] && !bit4_prev;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_cpu_start <= 1'b0;
    end else begin
      o_cpu_start <= (start_state == START_RUN) && !i_halt_release;
    end
  end

  // ==========================================================================
  // Interrupt status: a new event beats a clearing read
  // Bit 1 start event, bit 0 interval overflow
  assign irq_event = {start_event, tb_overflow};

  for (genvar b = 0; b < 2; b++) begin : g_status
    always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
        irq_status[b] <= 1'b0;
      end else begin
        irq_status[b] <= irq_event[b] || (irq_status[b] && !status_read);
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status & irq_mask);
    end
  end

  // ==========================================================================
  // Checks
  property p_count_steps;
    @(posedge i_sys_clk) disable iff (i_rst)
      $changed(timebase_counter) |-> (timebase_counter == 8'($past(timebase_counter) + 8'h01))
        || (timebase_counter == 8'h00);
  endproperty
  a_count_steps: assert property (p_count_steps) else $error("timebase jumped");

  property p_overflow_wrap;
    @(posedge i_sys_clk) disable iff (i_rst)
      tb_overflow |=> (timebase_counter == 8'h00) && irq_status[`TBW_IRQ_INTERVAL_BIT] ##1 o_irq || !irq_mask[0];
  endproperty
  a_overflow_wrap: assert property (p_overflow_wrap) else $error("overflow did not wrap or flag");

  property p_guard_cause;
    @(posedge i_sys_clk) disable iff (i_rst)
      $changed(guard_counter) |-> $past(tb_overflow) || $past(clr_guard);
  endproperty
  a_guard_cause: assert property (p_guard_cause) else $error("guard moved without overflow");

  property p_guard_reset;
    @(posedge i_sys_clk) disable iff (i_rst)
      (guard_enabled && tb_overflow && !clr_guard && guard_counter == 3'h7) |=> o_guard_reset ##1 !o_guard_reset;
  endproperty
  a_guard_reset: assert property (p_guard_reset) else $error("guard overflow gave no reset pulse");

  property p_guard_stop;
    @(posedge i_sys_clk) disable iff (i_rst)
      (guard_code == `TBW_GUARD_STOP_CODE && !clr_guard) |=> $stable(guard_counter) && !o_guard_reset;
  endproperty
  a_guard_stop: assert property (p_guard_stop) else $error("stopped guard counted");

  property p_reset_defaults;
    @(posedge i_sys_clk)
      i_rst |=> (guard_code == 8'h00) && (clk_sel == 2'h0) && (guard_counter == 3'h0)
        && (timebase_counter == 8'h00) && !o_cpu_start;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("reset values wrong");

  property p_guard_clear;
    @(posedge i_sys_clk) disable iff (i_rst)
      (wr_access && paddr == `TBW_ADDR_CONTROL && pstrb[0] && pwdata[0]) |=> ##1 (guard_counter == 3'h0);
  endproperty
  a_guard_clear: assert property (p_guard_clear) else $error("guard clear ignored");

  property p_tb_clear;
    @(posedge i_sys_clk) disable iff (i_rst)
      (wr_access && paddr == `TBW_ADDR_CONTROL && pstrb[0] && pwdata[1]) |=> ##1 (timebase_counter == 8'h00);
  endproperty
  a_tb_clear: assert property (p_tb_clear) else $error("timebase clear ignored");

  property p_start_gate;
    @(posedge i_sys_clk) disable iff (i_rst)
      $rose(o_cpu_start) |-> $past(timebase_counter[4], 2) && !$past(timebase_counter[4], 3);
  endproperty
  a_start_gate: assert property (p_start_gate) else $error("start before bit 4 rose");

  property p_stop_hold;
    @(posedge i_sys_clk) disable iff (i_rst)
      (tb_stop && !clr_tb) |=> $stable(timebase_counter);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stopped timebase moved");

  property p_clear_pulse;
    @(posedge i_sys_clk) disable iff (i_rst)
      (clr_guard || clr_tb) |=> !clr_guard && !clr_tb;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("clear bit did not self clear");

  property p_irq_level;
    @(posedge i_sys_clk) disable iff (i_rst)
      1'b1 |=> (o_irq == (|($past(irq_status & irq_mask))));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");
endmodule : basic_timer_watchdog

// file: sys_reset_logic.sv
module sys_reset_logic (
  input  wire logic i_sys_clk,
  input  wire logic i_por,
  input  wire logic i_guard_reset,
  output logic      o_rst,
  output int        o_guard_hits
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Reset stretcher
  logic [2:0] hold;
  int         hits;
  // Stretched so the whole device sees a clean multi-cycle reset
  always_ff @(posedge i_sys_clk) begin
    if (i_por) begin
      hold <= 3'h0;
      hits <= 0;
    end else if (i_guard_reset) begin
      hold <= 3'h6;
      hits <= hits + 1;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
  end
  assign o_rst        = i_por | (hold != 3'h0);
  assign o_guard_hits = hits;
endmodule : sys_reset_logic

// file: basic_timer_watchdog_tb.sv
`include "basic_timer_watchdog_regs.svh"
module basic_timer_watchdog_tb
  import basic_timer_watchdog_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_sys_clk = 1'b0;
  logic        por = 1'b1;
  logic        i_rst;
  logic        i_halt_release = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic        o_irq;
  logic        o_guard_reset;
  logic        o_cpu_start;
  int          guard_hits;
  int          err_total = 0;
  int          tests_run = 0;
  logic [31:0] d;
  logic [31:0] a;
  logic        e;
  int          n;

  always #5 i_sys_clk = ~i_sys_clk;

  basic_timer_watchdog uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_halt_release(i_halt_release),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq),
    .o_guard_reset(o_guard_reset), .o_cpu_start(o_cpu_start));

  sys_reset_logic rst_model (.i_sys_clk(i_sys_clk), .i_por(por), .i_guard_reset(o_guard_reset),
    .o_rst(i_rst), .o_guard_hits(guard_hits));

  // ==========================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [17:0] ad, input logic [31:0] wd);
    @(posedge i_sys_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge i_sys_clk);
    end while (o_pready !== 1'b1);
    d = o_prdata;
    e = o_pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wait_start(input int lim);
    n = 0;
    while (o_cpu_start !== 1'b1 && n < lim) begin
      @(posedge i_sys_clk);
      n++;
    end
  endtask : wait_start

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // ==========================================
  // Scenarios
  task automatic t_reset_values();
    xfer(1'b0, `TBW_ADDR_CONTROL, 32'h0);
    chk("control", d, 32'h0);
    xfer(1'b0, `TBW_ADDR_COUNT, 32'h0);
    chk("count", d, 32'h0);
    xfer(1'b0, `TBW_ADDR_SYS_CONFIG, 32'h0);
    chk("config", d, 32'h0);
    chk("start", o_cpu_start, 1'b0);
  endtask : t_reset_values

  task automatic t_refusal();
    xfer(1'b0, 18'h28004, 32'h0);
    chk("unmapped err", e, 1'b1);
    xfer(1'b1, `TBW_ADDR_COUNT, 32'hFF);
    xfer(1'b0, `TBW_ADDR_COUNT, 32'h0);
    chk("count write", d, 32'h0);
    xfer(1'b1, `TBW_ADDR_CONTROL, 32'hA50C);
    xfer(1'b0, `TBW_ADDR_CONTROL, 32'h0);
    chk("stop code", d, 32'hA50C);
  endtask : t_refusal

  task automatic t_start_irq();
    wait_start(20480);
    chk("start delay", (n > 7000) && (n < 9000), 1'b1);
    repeat (3) @(posedge i_sys_clk);
    chk("irq masked", o_irq, 1'b0);
    xfer(1'b0, `TBW_ADDR_IRQ_STATUS, 32'h0);
    chk("status", d, 32'h2);
    xfer(1'b0, `TBW_ADDR_IRQ_STATUS, 32'h0);
    chk("status cleared", d, 32'h0);
    xfer(1'b1, `TBW_ADDR_IRQ_MASK, 32'h2);
    @(posedge i_sys_clk);
    i_halt_release <= 1'b1;
    @(posedge i_sys_clk);
    i_halt_release <= 1'b0;
    @(posedge i_sys_clk);
    #1 chk("start drop", o_cpu_start, 1'b0);
    wait_start(20480);
    chk("halt delay", (n > 14000) && (n < 17000), 1'b1);
    repeat (3) @(posedge i_sys_clk);
    chk("irq", o_irq, 1'b1);
    xfer(1'b0, `TBW_ADDR_IRQ_STATUS, 32'h0);
    repeat (2) @(posedge i_sys_clk);
    chk("irq clear", o_irq, 1'b0);
  endtask : t_start_irq

  task automatic t_dividers();
    int exps[4] = '{13, 12, 11, 9};
    for (int i = 0; i < 4; i++) begin
      // Kick guard and clear count in one write, as software would
      xfer(1'b1, `TBW_ADDR_CONTROL, {28'h0, i[1:0], 2'b11});
      xfer(1'b0, `TBW_ADDR_CONTROL, 32'h0);
      chk("self clear", d, {28'h0, i[1:0], 2'b00});
      repeat (2 << exps[i]) @(posedge i_sys_clk);
      xfer(1'b0, `TBW_ADDR_COUNT, 32'h0);
      chk("ticks", (d >= 32'h1) && (d <= 32'h3), 1'b1);
    end
  endtask : t_dividers

  task automatic t_stop();
    xfer(1'b1, `TBW_ADDR_SYS_CONFIG, 32'h40);
    xfer(1'b0, `TBW_ADDR_COUNT, 32'h0);
    a = d;
    repeat (1100) @(posedge i_sys_clk);
    xfer(1'b0, `TBW_ADDR_COUNT, 32'h0);
    chk("halted", d, a);
    xfer(1'b1, `TBW_ADDR_SYS_CONFIG, 32'h0);
    repeat (1100) @(posedge i_sys_clk);
    xfer(1'b0, `TBW_ADDR_COUNT, 32'h0);
    chk("resumed", d != a, 1'b1);
    chk("guard resets", guard_hits, 32'h0);
  endtask : t_stop

  task automatic t_mid_reset();
    @(posedge i_sys_clk);
    por <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    por <= 1'b0;
    chk("start after reset", o_cpu_start, 1'b0);
    xfer(1'b0, `TBW_ADDR_CONTROL, 32'h0);
    chk("control after reset", d, 32'h0);
    xfer(1'b0, `TBW_ADDR_COUNT, 32'h0);
    chk("count after reset", d, 32'h0);
    xfer(1'b0, `TBW_ADDR_SYS_CONFIG, 32'h0);
    chk("config after reset", d, 32'h0);
  endtask : t_mid_reset

  // ==========================================
  // Main sequence
  initial begin
    repeat (6) @(posedge i_sys_clk);
    por <= 1'b0;
    t_reset_values();
    t_refusal();
    t_start_irq();
    t_dividers();
    t_stop();
    t_mid_reset();
    end_of_test();
  end

  // Sized for roughly two and a half times the expected run
  initial begin
    #1_500_000;
    err_total++;
    $display("Watchdog expired");
    end_of_test();
  end
endmodule : basic_timer_watchdog_tb
